// ==== pkg/fbap_pkg.sv ====
// Purpose: types of the blend and audio property bank
// Assumes: nothing beyond the constants header
// Notes: no constants here, they live in fbap_regs.svh
`default_nettype none

package fbap_pkg;

    // command sequencer, gray along idle, exec, done
    typedef enum logic [1:0] {
        FBAP_IDLE = 2'b00,
        FBAP_EXEC = 2'b01,
        FBAP_DONE = 2'b11
    } fbap_state_t;

    // index of a property cell
    typedef logic [3:0] fbap_prop_idx_t;

endpackage

`default_nettype wire

// ==== pkg/fbap_regs.svh ====
// Purpose: constants of the blend and audio property bank
// Assumes: 16-bit property numbers and values, 50 MHz clock
// Notes: definitions only, no logic
`ifndef FBAP_REGS_SVH
`define FBAP_REGS_SVH

// command codes
`define FBAP_CMD_SET_PROPERTY 8'h12
`define FBAP_CMD_PROPERTY_READ 8'h13

// property numbers
`define FBAP_SNR_STEREO_THRESHOLD_OFS 16'h1804
`define FBAP_SNR_MONO_THRESHOLD_OFS 16'h1805
`define FBAP_SNR_ATTACK_RATE_OFS 16'h1806
`define FBAP_SNR_RELEASE_RATE_OFS 16'h1807
`define FBAP_MULTIPATH_STEREO_THRESHOLD_OFS 16'h1808
`define FBAP_MULTIPATH_MONO_THRESHOLD_OFS 16'h1809
`define FBAP_MULTIPATH_ATTACK_RATE_OFS 16'h180a
`define FBAP_MULTIPATH_RELEASE_RATE_OFS 16'h180b
`define FBAP_OUTPUT_LEVEL_OFS 16'h4000
`define FBAP_OUTPUT_SILENCE_OFS 16'h4001
`define FBAP_RF_GAIN_ATTACK_OFS 16'h4100

// reset values
`define FBAP_SNR_STEREO_THRESHOLD_RST 16'h001e
`define FBAP_SNR_MONO_THRESHOLD_RST 16'h000a
`define FBAP_SNR_ATTACK_RATE_RST 16'h03e8
`define FBAP_SNR_RELEASE_RATE_RST 16'h0064
`define FBAP_MULTIPATH_STEREO_THRESHOLD_RST 16'h0028
`define FBAP_MULTIPATH_MONO_THRESHOLD_RST 16'h000a
`define FBAP_MULTIPATH_ATTACK_RATE_RST 16'h03e8
`define FBAP_MULTIPATH_RELEASE_RATE_RST 16'h000a
`define FBAP_OUTPUT_LEVEL_RST 16'h003f
`define FBAP_OUTPUT_SILENCE_RST 16'h0000
`define FBAP_RF_GAIN_ATTACK_RST 16'h0001

// field widths and upper limits
`define FBAP_SNR_THRESHOLD_W 7
`define FBAP_SNR_THRESHOLD_MAX 16'h007f
`define FBAP_MULTIPATH_THRESHOLD_W 7
`define FBAP_MULTIPATH_THRESHOLD_MAX 16'h0032
`define FBAP_RATE_W 16
`define FBAP_RATE_MAX 16'h7fff
`define FBAP_OUTPUT_LEVEL_W 6
`define FBAP_OUTPUT_LEVEL_MAX 16'h003f
`define FBAP_OUTPUT_SILENCE_W 2
`define FBAP_OUTPUT_SILENCE_MAX 16'h0003
`define FBAP_RF_GAIN_ATTACK_W 8
`define FBAP_RF_GAIN_ATTACK_MAX 16'h00f8

// field positions
`define FBAP_LEFT_SILENCE_BIT 1
`define FBAP_RIGHT_SILENCE_BIT 0

// rf attack legacy value and its effective floor
`define FBAP_RF_ATTACK_LEGACY 16'h0001
`define FBAP_RF_ATTACK_FLOOR 16'h0004

// command busy time
`define FBAP_CTS_TIME_NS 300
`define FBAP_CLK_PERIOD_NS 20

`endif

// ==== sim/fbap_bank_checker.sv ====
// Purpose: protocol and range checks on the property bank ports
// Assumes: bound onto fbap_bank, one clock domain
// Notes: busy length is counted in helper logic, not unrolled
`timescale 1ns/1ps
`default_nettype none

module fbap_bank_checker #(
    parameter int CTS_CYCLES = 15
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // command and response
    input wire logic i_cmd_valid,
    input wire logic o_cts,
    input wire logic o_resp_valid,
    input wire logic o_resp_error,
    input wire logic [15:0] o_resp_data,
    // settings
    input wire logic [15:0] o_snr_attack_rate,
    input wire logic o_snr_attack_en,
    input wire logic [15:0] o_mp_release_rate,
    input wire logic o_mp_release_en,
    input wire logic [6:0] o_mp_stereo_limit_field,
    input wire logic [6:0] o_mp_mono_limit_field,
    input wire logic [5:0] o_output_level_field,
    input wire logic o_left_silence_bit,
    input wire logic [7:0] o_rf_gain_attack
);
    int busy_cnt_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // busy cycles since cts fell; cleared whenever idle
    always_ff @(posedge i_clk) begin
        if (i_srst || o_cts) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    chk_cts_take: assert property (o_cts && i_cmd_valid |=> !o_cts)
        else $error("cts stayed high after a taken command");
    chk_resp_timing: assert property (
        o_resp_valid |-> o_cts && busy_cnt_r == CTS_CYCLES + 1)
        else $error("response not at the fixed busy length");
    chk_busy_bound: assert property (!o_cts |-> busy_cnt_r <= CTS_CYCLES)
        else $error("busy lasted too long");
    chk_resp_pulse: assert property (o_resp_valid |=> !o_resp_valid)
        else $error("response pulse longer than one cycle");
    chk_cts_return: assert property ($rose(o_cts) |-> o_resp_valid)
        else $error("cts rose without a response");
    chk_error_data: assert property (
        o_resp_valid && o_resp_error |-> o_resp_data == 16'h0000)
        else $error("refused command returned data");
    chk_attack_enable: assert property (
        o_snr_attack_en == (o_snr_attack_rate != 16'h0000) && o_snr_attack_rate <= 16'h7fff)
        else $error("snr attack enable or range wrong");
    chk_release_enable: assert property (
        o_mp_release_en == (o_mp_release_rate != 16'h0000))
        else $error("multipath release enable wrong");
    chk_mp_range: assert property (
        o_mp_stereo_limit_field <= 7'h32 && o_mp_mono_limit_field <= 7'h32)
        else $error("multipath threshold above limit");
    chk_level_hold: assert property (
        $changed(o_output_level_field) || $changed(o_left_silence_bit) |-> $past(o_resp_valid))
        else $error("audio setting changed without a response");
    chk_rf_range: assert property (
        o_rf_gain_attack >= 8'h04 && o_rf_gain_attack <= 8'hf8)
        else $error("rf attack outside 4 to 248");

    // main scenarios reached
    cov_set_ok: cover property (o_resp_valid && !o_resp_error);
    cov_refused: cover property (o_resp_valid && o_resp_error);
    cov_rf_top: cover property (o_rf_gain_attack == 8'hf8);
endmodule

`default_nettype wire

// ==== sim/fbap_bank_tb_top.sv ====
// Purpose: self-checking bench of the property bank
// Assumes: short busy time to keep the run brief
// Notes: controller model drives every command input
`timescale 1ns/1ps
`default_nettype none

`include "fbap_regs.svh"

module fbap_bank_tb_top;
    localparam int CTS = 4;
    localparam logic [7:0] SET = `FBAP_CMD_SET_PROPERTY;
    localparam logic [7:0] GET = `FBAP_CMD_PROPERTY_READ;
    logic clk, srst, pwr, cvalid, cts, rvalid, rerr, sae, sre, mae, mre, lsil, rsil;
    logic [7:0] code, rf;
    logic [15:0] num, val, rdata, sar, srr, mar, mrr;
    logic [6:0] sst, smo, mst, mmo;
    logic [5:0] lvl;
    logic err;
    logic [15:0] data;
    int lat, num_errors, check_count, cycles;
    logic [15:0] nums [11] = '{16'h1804, 16'h1805, 16'h1806, 16'h1807, 16'h1808,
        16'h1809, 16'h180a, 16'h180b, 16'h4000, 16'h4001, 16'h4100};
    logic [15:0] rsts [11] = '{16'h001e, 16'h000a, 16'h03e8, 16'h0064, 16'h0028,
        16'h000a, 16'h03e8, 16'h000a, 16'h003f, 16'h0000, 16'h0001};
    logic [15:0] wvals [11] = '{16'hffff, 16'h000e, 16'h8000, 16'h0000, 16'h0033,
        16'h0000, 16'h0001, 16'h7fff, 16'h0000, 16'h0002, 16'h0002};
    logic [15:0] rbs [11] = '{16'h007f, 16'h000e, 16'h7fff, 16'h0000, 16'h0032,
        16'h0000, 16'h0001, 16'h7fff, 16'h0000, 16'h0002, 16'h0002};

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    fbap_bank #(.CTS_CYCLES(CTS)) i_fbap_bank (.i_clk(clk), .i_srst(srst),
        .i_powered_up(pwr), .i_cmd_valid(cvalid), .i_cmd_code(code), .i_prop_num(num),
        .i_prop_val(val), .o_cts(cts), .o_resp_valid(rvalid), .o_resp_error(rerr),
        .o_resp_data(rdata), .o_snr_stereo_limit_field(sst), .o_snr_mono_limit_field(smo),
        .o_snr_attack_rate(sar), .o_snr_release_rate(srr), .o_snr_attack_en(sae),
        .o_snr_release_en(sre), .o_mp_stereo_limit_field(mst), .o_mp_mono_limit_field(mmo),
        .o_mp_attack_rate(mar), .o_mp_release_rate(mrr), .o_mp_attack_en(mae),
        .o_mp_release_en(mre), .o_output_level_field(lvl), .o_left_silence_bit(lsil),
        .o_right_silence_bit(rsil), .o_rf_gain_attack(rf));

    fbap_ctrl_model i_fbap_ctrl_model (.i_clk(clk), .i_cts(cts), .i_resp_valid(rvalid),
        .i_resp_error(rerr), .i_resp_data(rdata), .o_powered_up(pwr), .o_cmd_valid(cvalid),
        .o_cmd_code(code), .o_prop_num(num), .o_prop_val(val));

    // comparison of any design value, widened to 16 bits
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one command with error and latency checked; gap varies the pace
    task automatic xfer(input logic [7:0] c, input logic [15:0] n, input logic [15:0] v,
            input logic exp_err);
        i_fbap_ctrl_model.run_cmd(c, n, v, check_count % 3, err, data, lat);
        chk("resp_error", {15'h0000, exp_err}, {15'h0000, err});
        chk("latency", 16'(CTS + 2), 16'(lat));
    endtask

    task automatic t_reset_values();
        for (int k = 0; k < 11; k++) begin
            xfer(GET, nums[k], 16'h0000, 1'b0);
            chk("reset readback", rsts[k], data);
        end
        chk("rf effective", 16'h0004, {8'h00, rf});
        chk("enables", 16'h000f, {12'h000, sae, sre, mae, mre});
        chk("silence", 16'h0000, {14'h0000, lsil, rsil});
        $display("test reset_values done, errors %0d", num_errors);
    endtask

    task automatic t_write_read();
        for (int k = 0; k < 11; k++) begin
            xfer(SET, nums[k], wvals[k], 1'b0);
            xfer(GET, nums[k], 16'h0000, 1'b0);
            chk("readback", rbs[k], data);
        end
        chk("snr stereo", 16'h007f, {9'h000, sst});
        chk("mp stereo", 16'h0032, {9'h000, mst});
        chk("snr attack", 16'h7fff, sar);
        chk("enables", 16'h000b, {12'h000, sae, sre, mae, mre});
        chk("level", 16'h0000, {10'h000, lvl});
        chk("silence", 16'h0002, {14'h0000, lsil, rsil});
        chk("snr mono", 16'h000e, {9'h000, smo});
        chk("mp mono", 16'h0000, {9'h000, mmo});
        chk("snr release", 16'h0000, srr);
        chk("mp attack", 16'h0001, mar);
        chk("mp release", 16'h7fff, mrr);
        chk("rf effective", 16'h0004, {8'h00, rf});
        xfer(SET, 16'h4001, 16'h0001, 1'b0);
        xfer(SET, 16'h4100, 16'h00fc, 1'b0);
        xfer(SET, 16'h4000, 16'h003f, 1'b0);
        @(negedge clk);
        chk("silence", 16'h0001, {14'h0000, lsil, rsil});
        chk("rf top", 16'h00f8, {8'h00, rf});
        chk("level", 16'h003f, {10'h000, lvl});
        $display("test write_read done, errors %0d", num_errors);
    endtask

    task automatic t_refusals();
        i_fbap_ctrl_model.set_power(1'b0);
        xfer(SET, 16'h4000, 16'h0005, 1'b1);
        xfer(GET, 16'h4000, 16'h0000, 1'b1);
        chk("refused data", 16'h0000, data);
        i_fbap_ctrl_model.set_power(1'b1);
        xfer(GET, 16'h4000, 16'h0000, 1'b0);
        chk("level kept", 16'h003f, data);
        xfer(8'h14, 16'h4000, 16'h0001, 1'b1);
        xfer(SET, 16'h1800, 16'h0001, 1'b1);
        xfer(GET, 16'h4101, 16'h0000, 1'b1);
        $display("test refusals done, errors %0d", num_errors);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        srst = 1'b1;
        num_errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_reset_values();
        t_write_read();
        t_refusals();
        stop_test();
    end
endmodule

bind fbap_bank fbap_bank_checker #(.CTS_CYCLES(CTS_CYCLES)) i_fbap_bank_checker (
    .i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid), .o_cts(o_cts),
    .o_resp_valid(o_resp_valid), .o_resp_error(o_resp_error), .o_resp_data(o_resp_data),
    .o_snr_attack_rate(o_snr_attack_rate), .o_snr_attack_en(o_snr_attack_en),
    .o_mp_release_rate(o_mp_release_rate), .o_mp_release_en(o_mp_release_en),
    .o_mp_stereo_limit_field(o_mp_stereo_limit_field),
    .o_mp_mono_limit_field(o_mp_mono_limit_field),
    .o_output_level_field(o_output_level_field),
    .o_left_silence_bit(o_left_silence_bit), .o_rf_gain_attack(o_rf_gain_attack));

`default_nettype wire

// ==== sim/fbap_ctrl_model.sv ====
// Purpose: system controller issuing property commands
// Assumes: drives on the falling edge, device samples on the rising one
// Notes: released command lines carry inverted garbage, never the old value
`timescale 1ns/1ps
`default_nettype none

module fbap_ctrl_model (
    // clock
    input wire logic i_clk,
    // device answers
    input wire logic i_cts,
    input wire logic i_resp_valid,
    input wire logic i_resp_error,
    input wire logic [15:0] i_resp_data,
    // command lines
    output logic o_powered_up,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_code,
    output logic [15:0] o_prop_num,
    output logic [15:0] o_prop_val
);
    // idle, powered controller at time zero
    initial begin
        o_powered_up = 1'b1;
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_prop_num = 16'h0000;
        o_prop_val = 16'h0000;
    end

    // power state is only changed between commands
    task automatic set_power(input logic on);
        @(negedge i_clk);
        o_powered_up = on;
    endtask

    // one command; gap makes a slow controller
    task automatic run_cmd(input logic [7:0] code, input logic [15:0] num,
            input logic [15:0] val, input int gap, output logic err,
            output logic [15:0] data, output int lat);
        int n;
        n = 0;
        repeat (gap + 1) @(negedge i_clk);
        while (i_cts !== 1'b1 && n < 1000) begin
            @(negedge i_clk);
            n++;
        end
        o_cmd_valid = 1'b1;
        o_cmd_code = code;
        o_prop_num = num;
        o_prop_val = val;
        @(posedge i_clk);
        @(negedge i_clk);
        o_cmd_valid = 1'b0;
        o_cmd_code = ~code;
        o_prop_num = ~num;
        o_prop_val = ~val;
        lat = 1;
        while (i_resp_valid !== 1'b1 && lat < 1000) begin
            @(negedge i_clk);
            lat++;
        end
        err = i_resp_error;
        data = i_resp_data;
    endtask
endmodule

`default_nettype wire

// ==== src/fbap_bank.sv ====
// Purpose: blend, output level, silence and rf attack property bank
// Assumes: commands arrive already parsed from the serial control port
// Notes: cts is low from the accepted command until its response pulse
`timescale 1ns/1ps
`default_nettype none

`include "fbap_regs.svh"

module fbap_bank #(
    parameter int CTS_CYCLES = (`FBAP_CTS_TIME_NS + `FBAP_CLK_PERIOD_NS - 1) / `FBAP_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // power state
    input wire logic i_powered_up,
    // command port
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic [15:0] i_prop_num,
    input wire logic [15:0] i_prop_val,
    output logic o_cts,
    // response port
    output logic o_resp_valid,
    output logic o_resp_error,
    output logic [15:0] o_resp_data,
    // snr blend settings
    output logic [6:0] o_snr_stereo_limit_field,
    output logic [6:0] o_snr_mono_limit_field,
    output logic [15:0] o_snr_attack_rate,
    output logic [15:0] o_snr_release_rate,
    output logic o_snr_attack_en,
    output logic o_snr_release_en,
    // multipath blend settings
    output logic [6:0] o_mp_stereo_limit_field,
    output logic [6:0] o_mp_mono_limit_field,
    output logic [15:0] o_mp_attack_rate,
    output logic [15:0] o_mp_release_rate,
    output logic o_mp_attack_en,
    output logic o_mp_release_en,
    // audio output settings
    output logic [5:0] o_output_level_field,
    output logic o_left_silence_bit,
    output logic o_right_silence_bit,
    // rf gain settings
    output logic [7:0] o_rf_gain_attack
);

    localparam int NPROP = 11;

    // the busy counter is eight bits wide
    generate
        if (CTS_CYCLES < 1 || CTS_CYCLES > 256) begin : g_bad_cts
            $error("fbap_bank: CTS_CYCLES must be 1 to 256");
        end
    endgenerate

    localparam logic [7:0] BUSY_LOAD = 8'(CTS_CYCLES - 1);

    fbap_pkg::fbap_state_t state_r;
    fbap_pkg::fbap_state_t state_nxt;
    logic [7:0] busy_r;
    logic [7:0] cmd_r;
    logic [15:0] num_r;
    logic [15:0] val_r;
    logic pwr_r;
    logic take;
    logic prop_hit;
    fbap_pkg::fbap_prop_idx_t prop_idx;
    logic is_set;
    logic is_get;
    logic cmd_ok;
    logic [NPROP-1:0] wr_sel;
    logic [15:0] prop_val [NPROP];
    logic [15:0] rd_data;

    // map a property number onto a cell index
    function automatic logic [4:0] fbap_decode(input logic [15:0] num);
        logic [4:0] r;
        r = 5'h00;
        case (num)
            `FBAP_SNR_STEREO_THRESHOLD_OFS: r = 5'h10;
            `FBAP_SNR_MONO_THRESHOLD_OFS: r = 5'h11;
            `FBAP_SNR_ATTACK_RATE_OFS: r = 5'h12;
            `FBAP_SNR_RELEASE_RATE_OFS: r = 5'h13;
            `FBAP_MULTIPATH_STEREO_THRESHOLD_OFS: r = 5'h14;
            `FBAP_MULTIPATH_MONO_THRESHOLD_OFS: r = 5'h15;
            `FBAP_MULTIPATH_ATTACK_RATE_OFS: r = 5'h16;
            `FBAP_MULTIPATH_RELEASE_RATE_OFS: r = 5'h17;
            `FBAP_OUTPUT_LEVEL_OFS: r = 5'h18;
            `FBAP_OUTPUT_SILENCE_OFS: r = 5'h19;
            `FBAP_RF_GAIN_ATTACK_OFS: r = 5'h1a;
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    // a command is taken only while cts is high
    assign o_cts = (state_r == fbap_pkg::FBAP_IDLE);
    assign take = o_cts && i_cmd_valid;

    // decode of the latched command
    always_comb begin
        logic [4:0] d;
        d = fbap_decode(num_r);
        prop_hit = d[4];
        prop_idx = d[3:0];
        is_set = (cmd_r == `FBAP_CMD_SET_PROPERTY);
        is_get = (cmd_r == `FBAP_CMD_PROPERTY_READ);
        cmd_ok = pwr_r && prop_hit && (is_set || is_get);
    end

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fbap_pkg::FBAP_IDLE: begin
                if (take) begin
                    state_nxt = fbap_pkg::FBAP_EXEC;
                end
            end
            fbap_pkg::FBAP_EXEC: begin
                if (busy_r == 8'h00) begin
                    state_nxt = fbap_pkg::FBAP_DONE;
                end
            end
            fbap_pkg::FBAP_DONE: begin
                state_nxt = fbap_pkg::FBAP_IDLE;
            end
            default: begin
                state_nxt = fbap_pkg::FBAP_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= fbap_pkg::FBAP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // busy count holds cts low for the command time
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            busy_r <= 8'h00;
        end else if (take) begin
            busy_r <= BUSY_LOAD;
        end else if (state_r == fbap_pkg::FBAP_EXEC && busy_r != 8'h00) begin
            busy_r <= busy_r - 8'h01;
        end
    end

    // latch the command; power is sampled when the command is taken
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmd_r <= 8'h00;
            num_r <= 16'h0000;
            val_r <= 16'h0000;
            pwr_r <= 1'b0;
        end else if (take) begin
            cmd_r <= i_cmd_code;
            num_r <= i_prop_num;
            val_r <= i_prop_val;
            pwr_r <= i_powered_up;
        end
    end

    // one write strobe per accepted set command, only in done
    always_comb begin
        wr_sel = '0;
        if (state_r == fbap_pkg::FBAP_DONE && cmd_ok && is_set) begin
            wr_sel[prop_idx] = 1'b1;
        end
    end

    // property cells
    fbap_prop_cell #(
        .WIDTH(`FBAP_SNR_THRESHOLD_W),
        .MAX(`FBAP_SNR_THRESHOLD_MAX),
        .RESET(`FBAP_SNR_STEREO_THRESHOLD_RST)
    ) u_snr_stereo (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[0]),
        .i_wr_data(val_r), .o_value(prop_val[0])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_SNR_THRESHOLD_W),
        .MAX(`FBAP_SNR_THRESHOLD_MAX),
        .RESET(`FBAP_SNR_MONO_THRESHOLD_RST)
    ) u_snr_mono (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[1]),
        .i_wr_data(val_r), .o_value(prop_val[1])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_RATE_W),
        .MAX(`FBAP_RATE_MAX),
        .RESET(`FBAP_SNR_ATTACK_RATE_RST)
    ) u_snr_attack (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[2]),
        .i_wr_data(val_r), .o_value(prop_val[2])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_RATE_W),
        .MAX(`FBAP_RATE_MAX),
        .RESET(`FBAP_SNR_RELEASE_RATE_RST)
    ) u_snr_release (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[3]),
        .i_wr_data(val_r), .o_value(prop_val[3])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_MULTIPATH_THRESHOLD_W),
        .MAX(`FBAP_MULTIPATH_THRESHOLD_MAX),
        .RESET(`FBAP_MULTIPATH_STEREO_THRESHOLD_RST)
    ) u_mp_stereo (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[4]),
        .i_wr_data(val_r), .o_value(prop_val[4])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_MULTIPATH_THRESHOLD_W),
        .MAX(`FBAP_MULTIPATH_THRESHOLD_MAX),
        .RESET(`FBAP_MULTIPATH_MONO_THRESHOLD_RST)
    ) u_mp_mono (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[5]),
        .i_wr_data(val_r), .o_value(prop_val[5])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_RATE_W),
        .MAX(`FBAP_RATE_MAX),
        .RESET(`FBAP_MULTIPATH_ATTACK_RATE_RST)
    ) u_mp_attack (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[6]),
        .i_wr_data(val_r), .o_value(prop_val[6])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_RATE_W),
        .MAX(`FBAP_RATE_MAX),
        .RESET(`FBAP_MULTIPATH_RELEASE_RATE_RST)
    ) u_mp_release (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[7]),
        .i_wr_data(val_r), .o_value(prop_val[7])
    );

    // upper bits of the level word are dropped, not trusted
    fbap_prop_cell #(
        .WIDTH(`FBAP_OUTPUT_LEVEL_W),
        .MAX(`FBAP_OUTPUT_LEVEL_MAX),
        .RESET(`FBAP_OUTPUT_LEVEL_RST)
    ) u_level (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[8]),
        .i_wr_data(val_r), .o_value(prop_val[8])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_OUTPUT_SILENCE_W),
        .MAX(`FBAP_OUTPUT_SILENCE_MAX),
        .RESET(`FBAP_OUTPUT_SILENCE_RST)
    ) u_silence (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[9]),
        .i_wr_data(val_r), .o_value(prop_val[9])
    );

    fbap_prop_cell #(
        .WIDTH(`FBAP_RF_GAIN_ATTACK_W),
        .MAX(`FBAP_RF_GAIN_ATTACK_MAX),
        .RESET(`FBAP_RF_GAIN_ATTACK_RST)
    ) u_rf_attack (
        .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_sel[10]),
        .i_wr_data(val_r), .o_value(prop_val[10])
    );

    // read mux; readback shows the stored word, not the effective one
    always_comb begin
        rd_data = 16'h0000;
        if (prop_hit && prop_idx < 4'(NPROP)) begin
            rd_data = prop_val[prop_idx];
        end
    end

    // response pulse at the end of the busy time
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_resp_valid <= 1'b0;
            o_resp_error <= 1'b0;
            o_resp_data <= 16'h0000;
        end else if (state_r == fbap_pkg::FBAP_DONE) begin
            o_resp_valid <= 1'b1;
            o_resp_error <= !cmd_ok;
            o_resp_data <= (cmd_ok && is_get) ? rd_data : 16'h0000;
        end else begin
            o_resp_valid <= 1'b0;
        end
    end

    // settings towards the blend, audio and gain logic, one clock behind the cells
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_snr_stereo_limit_field <= 7'(`FBAP_SNR_STEREO_THRESHOLD_RST);
            o_snr_mono_limit_field <= 7'(`FBAP_SNR_MONO_THRESHOLD_RST);
            o_snr_attack_rate <= `FBAP_SNR_ATTACK_RATE_RST;
            o_snr_release_rate <= `FBAP_SNR_RELEASE_RATE_RST;
            o_mp_stereo_limit_field <= 7'(`FBAP_MULTIPATH_STEREO_THRESHOLD_RST);
            o_mp_mono_limit_field <= 7'(`FBAP_MULTIPATH_MONO_THRESHOLD_RST);
            o_mp_attack_rate <= `FBAP_MULTIPATH_ATTACK_RATE_RST;
            o_mp_release_rate <= `FBAP_MULTIPATH_RELEASE_RATE_RST;
            o_output_level_field <= 6'(`FBAP_OUTPUT_LEVEL_RST);
            o_snr_attack_en <= 1'b1;
            o_snr_release_en <= 1'b1;
            o_mp_attack_en <= 1'b1;
            o_mp_release_en <= 1'b1;
            o_left_silence_bit <= 1'b0;
            o_right_silence_bit <= 1'b0;
            o_rf_gain_attack <= 8'(`FBAP_RF_ATTACK_FLOOR);
        end else begin
            o_snr_stereo_limit_field <= prop_val[0][6:0];
            o_snr_mono_limit_field <= prop_val[1][6:0];
            o_snr_attack_rate <= prop_val[2];
            o_snr_release_rate <= prop_val[3];
            o_mp_stereo_limit_field <= prop_val[4][6:0];
            o_mp_mono_limit_field <= prop_val[5][6:0];
            o_mp_attack_rate <= prop_val[6];
            o_mp_release_rate <= prop_val[7];
            o_output_level_field <= prop_val[8][5:0];
            // a zero rate means the ramp is switched off
            o_snr_attack_en <= (prop_val[2] != 16'h0000);
            o_snr_release_en <= (prop_val[3] != 16'h0000);
            o_mp_attack_en <= (prop_val[6] != 16'h0000);
            o_mp_release_en <= (prop_val[7] != 16'h0000);
            // left and right silence act independently
            o_left_silence_bit <= prop_val[9][`FBAP_LEFT_SILENCE_BIT];
            o_right_silence_bit <= prop_val[9][`FBAP_RIGHT_SILENCE_BIT];
            // anything under the floor, the legacy reset 1 included, acts as 4
            o_rf_gain_attack <= (prop_val[10] < `FBAP_RF_ATTACK_FLOOR) ?
                8'(`FBAP_RF_ATTACK_FLOOR) : prop_val[10][7:0];
        end
    end

endmodule

`default_nettype wire

// ==== src/fbap_prop_cell.sv ====
// Purpose: one property word with a narrow field and an upper limit
// Assumes: write strobe is a one-cycle pulse
// Notes: bits above WIDTH are dropped on write and read as zero
`timescale 1ns/1ps
`default_nettype none

module fbap_prop_cell #(
    parameter int WIDTH = 16,
    parameter logic [15:0] MAX = 16'hffff,
    parameter logic [15:0] RESET = 16'h0000
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // write side
    input wire logic i_wr_en,
    input wire logic [15:0] i_wr_data,
    // stored value
    output logic [15:0] o_value
);

    localparam logic [15:0] MASK = 16'hffff >> (16 - WIDTH);

    // refuse shapes the cell cannot hold
    generate
        if (WIDTH < 1 || WIDTH > 16 || (MAX & ~MASK) != 16'h0000 || RESET > MAX) begin : g_bad
            $error("fbap_prop_cell: bad WIDTH, MAX or RESET");
        end
    endgenerate

    logic [15:0] value_r;
    logic [15:0] value_nxt;
    logic [15:0] masked;

    // drop upper bits, then saturate at the limit
    always_comb begin
        masked = i_wr_data & MASK;
        value_nxt = (masked > MAX) ? MAX : masked;
    end

    // storage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            value_r <= RESET;
        end else if (i_wr_en) begin
            value_r <= value_nxt;
        end
    end

    assign o_value = value_r;

endmodule

`default_nettype wire
